// [clock_seq_pkg.sv]
// shared constants and types for the clock return and wake sequencer
package clock_seq_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_SYS_MHZ    = 50;
  localparam int          CNT_W          = 11;
  localparam logic [10:0] STARTUP_EDGES  = 11'h400;  // 1024 primary edges
  localparam logic [10:0] HOLD_EDGES     = 11'h008;  // eight edges of the new clock
  localparam int          CPU_DELAY_US   = 5;        // least of the 5-10 us window
  localparam logic [7:0]  CPU_DELAY_CYC  = 8'(CPU_DELAY_US * CLK_SYS_MHZ);
  localparam int          STABLE_MS      = 4;
  localparam int          STABLE_CYC     = STABLE_MS * 1000 * CLK_SYS_MHZ;

  // ****************************************
  // clock select codes, also used for the running source
  // ****************************************
  localparam logic [1:0] SEL_PRIMARY   = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTERNAL  = 2'h2;
  localparam logic [1:0] SEL_RESERVED  = 2'h3;

  // ****************************************
  // primary source configuration codes and the low RC internal frequency code
  // ****************************************
  localparam logic [2:0] CFG_LOW_POWER_CRYSTAL  = 3'h0;
  localparam logic [2:0] CFG_STANDARD_CRYSTAL   = 3'h1;
  localparam logic [2:0] CFG_HIGH_SPEED_CRYSTAL = 3'h2;
  localparam logic [2:0] CFG_EXTERNAL_CLOCK     = 3'h3;
  localparam logic [2:0] CFG_INTERNAL_RC        = 3'h4;
  localparam logic [2:0] IFS_LOW_RC             = 3'h0;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_BOOT  = 3'b000,
    ST_FINAL = 3'b001,
    ST_RUN   = 3'b010,
    ST_START = 3'b011,
    ST_HOLD  = 3'b100,
    ST_SLEEP = 3'b101,
    ST_WAKE  = 3'b110
  } seq_state_e;

  function automatic logic is_crystal(input logic [2:0] cfg);
    is_crystal = (cfg == CFG_LOW_POWER_CRYSTAL) || (cfg == CFG_STANDARD_CRYSTAL) ||
                 (cfg == CFG_HIGH_SPEED_CRYSTAL);
  endfunction : is_crystal

endpackage : clock_seq_pkg

// [edge_window_counter.sv]
// counter of oscillator edges that restarts on every sequencer event
`timescale 1ns/1ps
module edge_window_counter
  import clock_seq_pkg::*;
(
  input  wire logic             clk_sys,    // system clock
  input  wire logic             reset,      // async reset, active high
  input  wire logic             restart,    // clear the count
  input  wire logic             edge_seen,  // one falling edge of the watched clock
  input  wire logic [CNT_W-1:0] target,     // edges to count
  output logic                  done        // target reached, held until restart
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } cnt_s;

  cnt_s r;
  cnt_s nx;

  always_comb begin
    nx = r;
    if (restart) begin
      nx.cnt  = '0;
      nx.done = 1'b0;
    end else if (edge_seen && !r.done) begin
      nx.cnt  = r.cnt + 11'h001;
      nx.done = (nx.cnt == target);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

  assign done = r.done;

endmodule : edge_window_counter

// [clock_return_and_wake_sequencer.sv]
// clock return, reset start-up and sleep wake sequencer
// Notes on behaviour
// - select 00 or secondary disable starts return
// - non-crystal primary skips start-up count
// - crystal waits 1024 edges, running on current
// - freeze phase, count eight new-clock edges
// - drop internal RC unless watchdog/monitor uses
// - secondary keeps running while enabled or while it is the source or target
// - reset clears select, no transition sequence
// - crystal reset holds core 1024 edges
// - two-speed runs internal RC during count
// - non-crystal reset waits short internal delay
// - timers in parallel, then one extra cycle
// - internal switch clears flags, stable after 4ms unless low RC selected
// - secondary needs enable, sets running flag
// - primary return sets started, clears running
// - sleep leaves select field untouched
// - any enabled interrupt wakes from sleep
// - wake on 00 with crystal waits both timers
// - wake on 01/10 waits CPU delay timer only
// - sleep during start-up count resumes primary
`timescale 1ns/1ps
module clock_return_and_wake_sequencer
  import clock_seq_pkg::*;
#(
  parameter int STABLE_DELAY = STABLE_CYC  // cycles until internal frequency is stable
) (
  input  wire logic       clk_sys,                    // system clock, 50 MHz
  input  wire logic       reset,                      // async reset, active high
  input  wire logic       sel_wr,                     // write strobe, clock select field
  input  wire logic [1:0] sel_wdata,                  // value written to clock select
  input  wire logic       sec_en_wr,                  // write strobe, secondary enable
  input  wire logic       sec_en_wdata,               // value written to secondary enable
  input  wire logic [2:0] primary_source_config,      // primary oscillator configuration
  input  wire logic [2:0] internal_freq_select,       // internal oscillator frequency
  input  wire logic       two_speed_en,               // two-speed start-up enabled
  input  wire logic       wdt_uses_irc,               // watchdog needs internal RC
  input  wire logic       fscm_uses_irc,              // clock monitor needs internal RC
  input  wire logic       sleep_cmd,                  // sleep instruction executed
  input  wire logic       wake_irq,                   // any enabled interrupt pending
  input  wire logic       prim_edge,                  // primary clock falling edge
  input  wire logic       sec_edge,                   // secondary clock falling edge
  input  wire logic       irc_edge,                   // internal RC falling edge
  output logic      [1:0] clock_select_field,         // selected clock source
  output logic            secondary_osc_enable,       // secondary oscillator enable bit
  output logic            primary_started_flag,       // running from primary
  output logic            internal_freq_stable_flag,  // internal frequency stable
  output logic            secondary_running_flag,     // running from secondary
  output logic      [1:0] sys_clk_source,             // source clocking the core
  output logic            phase_hold,                 // phases frozen in first phase
  output logic            cpu_run,                    // core executing
  output logic            sleeping,                   // device held in sleep
  output logic            prim_osc_en,                // primary oscillator powered
  output logic            irc_osc_en,                 // internal RC powered
  output logic            sec_osc_en                  // secondary oscillator powered
);

  localparam logic [17:0] STABLE_LAST = 18'(STABLE_DELAY - 1);

  typedef struct packed {
    seq_state_e  state;
    logic [1:0]  sel;
    logic        sec_en;
    logic [1:0]  src;
    logic [1:0]  tgt;
    logic        started;
    logic        freq_ok;
    logic        sec_live;
    logic        cpu_run;
    logic        phase_hold;
    logic        asleep;
    logic        prim_en;
    logic        irc_en;
    logic        sec_oen;
    logic [7:0]  cpu_tmr;
    logic [17:0] stable_tmr;
    logic        stable_busy;
  } seq_s;

  seq_s r;
  seq_s nx;

  logic ev_restart;
  logic start_done;
  logic hold_done;
  logic cpu_done;
  logic need_start;

  // ****************************************
  // decoding helpers
  // ****************************************
  // without the enable a secondary request falls back to primary; 11 means internal
  function automatic logic [1:0] resolve_sel(input logic [1:0] req, input logic en);
    if (req == SEL_RESERVED) begin
      resolve_sel = SEL_INTERNAL;
    end else if (req == SEL_SECONDARY && !en) begin
      resolve_sel = SEL_PRIMARY;
    end else begin
      resolve_sel = req;
    end
  endfunction : resolve_sel

  function automatic logic edge_of(input logic [1:0] s, input logic p, input logic c,
                                   input logic i);
    case (s)
      SEL_PRIMARY:   edge_of = p;
      SEL_SECONDARY: edge_of = c;
      default:       edge_of = i;
    endcase
  endfunction : edge_of

  assign cpu_done = (r.cpu_tmr == CPU_DELAY_CYC);
  assign need_start = (r.tgt == SEL_PRIMARY) && is_crystal(primary_source_config);

  // ****************************************
  // edge counters
  // ****************************************
  // any state change is a new event, so both windows start clean
  assign ev_restart = (nx.state != r.state);

  edge_window_counter u_start (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .restart   (ev_restart),
    .edge_seen (prim_edge),
    .target    (STARTUP_EDGES),
    .done      (start_done)
  );

  edge_window_counter u_hold (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .restart   (ev_restart),
    .edge_seen (edge_of(r.tgt, prim_edge, sec_edge, irc_edge)),
    .target    (HOLD_EDGES),
    .done      (hold_done)
  );

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    nx = r;
    // software reaches the control bits only while the core executes
    if (r.state == ST_RUN || r.state == ST_START) begin
      if (sec_en_wr) begin
        nx.sec_en = sec_en_wdata;
        if (!sec_en_wdata && r.sel == SEL_SECONDARY) begin
          nx.sel = SEL_PRIMARY;
        end
      end
      if (sel_wr) begin
        nx.sel = resolve_sel(sel_wdata, nx.sec_en);
      end
    end
    if (r.stable_busy) begin
      if (r.stable_tmr == STABLE_LAST) begin
        nx.freq_ok     = 1'b1;
        nx.stable_busy = 1'b0;
      end else begin
        nx.stable_tmr = r.stable_tmr + 18'h00001;
      end
    end
    case (r.state)
      ST_BOOT, ST_WAKE: begin
        if (!cpu_done) begin
          nx.cpu_tmr = r.cpu_tmr + 8'h01;
        end
        if (cpu_done && (!need_start || start_done)) begin
          if (r.state == ST_BOOT) begin
            nx.state = ST_FINAL;
          end else begin
            nx.state      = ST_RUN;
            nx.src        = r.tgt;
            nx.cpu_run    = 1'b1;
            nx.phase_hold = 1'b0;
            nx.asleep     = 1'b0;
            nx.started    = (r.tgt == SEL_PRIMARY);
            nx.sec_live   = (r.tgt == SEL_SECONDARY);
          end
        end else if (cpu_done && need_start && two_speed_en) begin
          nx.src        = SEL_INTERNAL;
          nx.cpu_run    = 1'b1;
          nx.phase_hold = 1'b0;
          nx.asleep     = 1'b0;
        end
      end
      ST_FINAL: begin
        nx.state      = ST_RUN;
        nx.src        = SEL_PRIMARY;
        nx.cpu_run    = 1'b1;
        nx.phase_hold = 1'b0;
        nx.started    = 1'b1;
        nx.sec_live   = 1'b0;
      end
      ST_RUN: begin
        if (nx.sel != r.src) begin
          nx.tgt = nx.sel;
          if (nx.sel == SEL_PRIMARY && is_crystal(primary_source_config)) begin
            nx.state = ST_START;
          end else begin
            nx.state = ST_HOLD;
          end
          if (nx.sel != SEL_PRIMARY) begin
            nx.started = 1'b0;
          end
          if (nx.sel == SEL_INTERNAL) begin
            nx.sec_live    = 1'b0;
            nx.freq_ok     = 1'b0;
            nx.stable_tmr  = '0;
            nx.stable_busy = (internal_freq_select != IFS_LOW_RC);
          end
        end else if (sleep_cmd) begin
          nx.state = ST_SLEEP;
        end
      end
      ST_START: begin
        // the core keeps executing on the old source while the crystal starts
        if (start_done) begin
          nx.state = ST_HOLD;
        end else if (sleep_cmd) begin
          nx.state = ST_SLEEP;
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          nx.state      = ST_RUN;
          nx.src        = r.tgt;
          nx.cpu_run    = 1'b1;
          nx.phase_hold = 1'b0;
          if (r.tgt == SEL_PRIMARY) begin
            nx.started = 1'b1;
            nx.sec_live = 1'b0;
          end else if (r.tgt == SEL_SECONDARY) begin
            nx.sec_live = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_irq) begin
          nx.state   = ST_WAKE;
          nx.tgt     = r.sel;
          nx.cpu_tmr = '0;
        end
      end
      default: begin
        nx.state = ST_BOOT;
      end
    endcase
    if (nx.state == ST_HOLD) begin
      nx.phase_hold = 1'b1;
      nx.cpu_run    = 1'b0;
    end
    if (nx.state == ST_SLEEP) begin
      nx.asleep     = 1'b1;
      nx.phase_hold = 1'b1;
      nx.cpu_run    = 1'b0;
    end
    // ****************************************
    // oscillator power
    // ****************************************
    nx.prim_en = (nx.state != ST_SLEEP) &&
                 (nx.src == SEL_PRIMARY || nx.tgt == SEL_PRIMARY);
    nx.irc_en  = wdt_uses_irc || fscm_uses_irc ||
                 ((nx.state != ST_SLEEP) &&
                  (nx.src == SEL_INTERNAL || nx.tgt == SEL_INTERNAL));
    nx.sec_oen = nx.sec_en ||
                 ((nx.state != ST_SLEEP) &&
                  (nx.src == SEL_SECONDARY || nx.tgt == SEL_SECONDARY));
  end

  // reset lands on the primary with no transition sequence
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r            <= '0;
      r.state      <= ST_BOOT;
      r.sel        <= SEL_PRIMARY;
      r.src        <= SEL_PRIMARY;
      r.tgt        <= SEL_PRIMARY;
      r.phase_hold <= 1'b1;
      r.prim_en    <= 1'b1;
    end else begin
      r <= nx;
    end
  end

  assign clock_select_field        = r.sel;
  assign secondary_osc_enable      = r.sec_en;
  assign primary_started_flag      = r.started;
  assign internal_freq_stable_flag = r.freq_ok;
  assign secondary_running_flag    = r.sec_live;
  assign sys_clk_source            = r.src;
  assign phase_hold                = r.phase_hold;
  assign cpu_run                   = r.cpu_run;
  assign sleeping                  = r.asleep;
  assign prim_osc_en               = r.prim_en;
  assign irc_osc_en                = r.irc_en;
  assign sec_osc_en                = r.sec_oen;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_ask_primary;
    r.state == ST_RUN && sel_wr && sel_wdata == SEL_PRIMARY && r.src != SEL_PRIMARY;
  endsequence
  sequence s_hold_end;
    r.state == ST_HOLD && hold_done;
  endsequence
  property p_return_start;
    s_ask_primary |=> (r.state == ST_START || r.state == ST_HOLD) && r.tgt == SEL_PRIMARY;
  endproperty
  a_return_start: assert property (p_return_start) else $error("no return started");
  property p_skip_start;
    s_ask_primary ##0 !is_crystal(primary_source_config) |=> r.state == ST_HOLD;
  endproperty
  a_skip_start: assert property (p_skip_start) else $error("count not skipped");
  property p_start_runs_old;
    r.state == ST_START |-> r.cpu_run && !r.phase_hold && r.src != SEL_PRIMARY;
  endproperty
  a_start_runs_old: assert property (p_start_runs_old) else $error("core stopped");
  property p_hold_release;
    s_hold_end |=> r.state == ST_RUN && r.cpu_run && !r.phase_hold && r.src == $past(r.tgt);
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold not released");
  property p_hold_frozen;
    r.state == ST_HOLD |-> r.phase_hold && !r.cpu_run;
  endproperty
  a_hold_frozen: assert property (p_hold_frozen) else $error("phases not frozen");
  property p_irc_off;
    r.state == ST_RUN && $past(r.state) == ST_RUN && r.src != SEL_INTERNAL &&
    !$past(wdt_uses_irc) && !$past(fscm_uses_irc) |-> !r.irc_en;
  endproperty
  a_irc_off: assert property (p_irc_off) else $error("internal RC left running");
  property p_sec_follow;
    r.state == ST_RUN && $past(r.state) == ST_RUN && r.src != SEL_SECONDARY
      |-> r.sec_oen == r.sec_en;
  endproperty
  a_sec_follow: assert property (p_sec_follow) else $error("secondary power wrong");
  property p_boot_hold;
    r.state == ST_BOOT && !r.cpu_run |-> r.phase_hold && r.src == SEL_PRIMARY;
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("core not held");
  // with two-speed start-up the core already runs on the internal RC here
  property p_extra_cycle;
    r.state == ST_FINAL |-> r.cpu_run == (r.src == SEL_INTERNAL) ##1
      (r.state == ST_RUN && r.cpu_run && r.started);
  endproperty
  a_extra_cycle: assert property (p_extra_cycle) else $error("extra cycle missing");
  property p_sec_flags;
    s_hold_end ##0 r.tgt == SEL_SECONDARY |=> r.sec_live && !r.started;
  endproperty
  a_sec_flags: assert property (p_sec_flags) else $error("secondary flags wrong");
  property p_prim_flags;
    s_hold_end ##0 r.tgt == SEL_PRIMARY |=> r.started && !r.sec_live;
  endproperty
  a_prim_flags: assert property (p_prim_flags) else $error("primary flags wrong");
  property p_sleep_sel;
    r.state == ST_SLEEP |=> $stable(r.sel);
  endproperty
  a_sleep_sel: assert property (p_sleep_sel) else $error("select changed");
  property p_wake;
    r.state == ST_SLEEP && wake_irq |=> r.state == ST_WAKE && r.tgt == r.sel && r.asleep;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");

endmodule : clock_return_and_wake_sequencer

// [tb.sv]
// self-checking bench for the clock return and wake sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb
  import clock_seq_pkg::*;
;
  // ****************************************
  // stimulus and design
  // ****************************************
  logic       clk_sys = 1'b0, reset = 1'b1, sel_wr = 1'b0, sec_en_wr = 1'b0, sec_en_wdata = 1'b0;
  logic [1:0] sel_wdata = 2'h0, ph = 2'h0;
  logic [2:0] primary_source_config = 3'h1, internal_freq_select = 3'h3;
  logic       two_speed_en = 1'b0, wdt_uses_irc = 1'b0, fscm_uses_irc = 1'b0;
  logic       sleep_cmd = 1'b0, wake_irq = 1'b0, prim_edge = 1'b0, sec_edge = 1'b0, irc_edge = 1'b0;
  logic [1:0] clock_select_field, sys_clk_source;
  logic       secondary_osc_enable, primary_started_flag, internal_freq_stable_flag;
  logic       secondary_running_flag, phase_hold, cpu_run, sleeping;
  logic       prim_osc_en, irc_osc_en, sec_osc_en;
  int         n_mismatch = 0, checks_done = 0, c1, c2, p1, p2, lo;
  typedef struct {
    logic [2:0] cfg;
    logic       ew, en, sw;
    logic [1:0] sel, src;
    logic       st, rn, seco, irco, slow;
  } row_s;
  // cfg, en strobe, en, sel strobe, sel, src, started, running, sec osc, irc osc, crystal wait
  row_s rows[7] = '{'{3'h1, 1, 1, 1, 2'h1, 2'h1, 0, 1, 1, 0, 0}, '{3'h1, 0, 0, 1, 2'h2, 2'h2, 0, 0, 1, 1, 0},
    '{3'h1, 0, 0, 1, 2'h0, 2'h0, 1, 0, 1, 0, 1}, '{3'h1, 0, 0, 1, 2'h1, 2'h1, 0, 1, 1, 0, 0},
    '{3'h1, 1, 0, 0, 2'h0, 2'h0, 1, 0, 0, 0, 1}, '{3'h3, 1, 1, 1, 2'h1, 2'h1, 0, 1, 1, 0, 0},
    '{3'h3, 0, 0, 1, 2'h0, 2'h0, 1, 0, 1, 0, 0}};

  clock_return_and_wake_sequencer #(.STABLE_DELAY(20)) clock_return_and_wake_sequencer_i (
    .clk_sys, .reset, .sel_wr, .sel_wdata, .sec_en_wr, .sec_en_wdata, .primary_source_config,
    .internal_freq_select, .two_speed_en, .wdt_uses_irc, .fscm_uses_irc, .sleep_cmd, .wake_irq,
    .prim_edge, .sec_edge, .irc_edge, .clock_select_field, .secondary_osc_enable,
    .primary_started_flag, .internal_freq_stable_flag, .secondary_running_flag, .sys_clk_source,
    .phase_hold, .cpu_run, .sleeping, .prim_osc_en, .irc_osc_en, .sec_osc_en);

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // each oscillator gives one falling-edge pulse every fourth system cycle
  always @(negedge clk_sys) begin
    ph        <= ph + 2'h1;
    prim_edge <= (ph == 2'h0);
    sec_edge  <= (ph == 2'h1);
    irc_edge  <= (ph == 2'h2);
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  function automatic logic sig(input int w);
    sig = (w == 0) ? phase_hold : (w == 1) ? (cpu_run & ~phase_hold) : (sys_clk_source == 2'h0);
  endfunction : sig

  // waits for a condition, counting cycles, primary edges and cycles with the core stopped
  task automatic wait_sig(input int w, output int cyc, output int pe, output int stop);
    cyc = 0;
    pe = 0;
    stop = 0;
    while (sig(w) !== 1'b1) begin
      @(negedge clk_sys);
      cyc++;
      pe += prim_edge;
      stop += (cpu_run !== 1'b1);
      if (cyc > 20000) begin
        n_mismatch++;
        give_verdict();
      end
    end
  endtask : wait_sig

  task automatic wr(input logic ew, input logic en, input logic sw, input logic [1:0] sel);
    @(negedge clk_sys);
    {sec_en_wr, sec_en_wdata, sel_wr, sel_wdata} = {ew, en, sw, sel};
    @(negedge clk_sys);
    {sec_en_wr, sel_wr} = 2'b00;
  endtask : wr

  task automatic sleep_wake(input logic [1:0] esel, output int cyc, output int pe);
    sleep_cmd = 1'b1;
    @(negedge clk_sys);
    sleep_cmd = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("sleeping", 1'b1, sleeping)
    `CHK("cpu_run_asleep", 1'b0, cpu_run)
    wake_irq = 1'b1;
    @(negedge clk_sys);
    wake_irq = 1'b0;
    wait_sig(1, cyc, pe, lo);
    `CHK("awake", 1'b0, sleeping)
    `CHK("wake_sel", esel, clock_select_field)
    `CHK("wake_src", esel, sys_clk_source)
  endtask : sleep_wake

  task automatic restart(output int cyc, output int pe);
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (16) @(negedge clk_sys);
    `CHK("sel_rst", 2'h0, clock_select_field)
    `CHK("en_rst", 1'b0, secondary_osc_enable)
    `CHK("hold_rst", 1'b1, phase_hold)
    `CHK("prim_osc_rst", 1'b1, prim_osc_en)
    reset = 1'b0;
    wait_sig(1, cyc, pe, lo);
  endtask : restart

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    restart(c1, p1);
    `CHK("boot_startup", 1'b1, p1 >= 1024)
    `CHK("boot_cpu_timer", 1'b1, c1 >= 250)
    `CHK("boot_started", 1'b1, primary_started_flag)
    foreach (rows[i]) begin
      primary_source_config = rows[i].cfg;
      wr(rows[i].ew, rows[i].en, rows[i].sw, rows[i].sel);
      wait_sig(0, c1, p1, lo);
      if (rows[i].slow) begin
        `CHK("startup_edges", 1'b1, p1 >= 1024)
        // the core stops only in the cycle that first shows the hold
        `CHK("startup_core_runs", 1, lo)
      end else begin
        `CHK("no_startup", 1'b1, c1 <= 2)
      end
      wait_sig(1, c2, p2, lo);
      `CHK("hold_len", 1'b1, c2 >= 28)
      repeat (2) @(negedge clk_sys);
      `CHK("select", rows[i].sel, clock_select_field)
      `CHK("src", rows[i].src, sys_clk_source)
      `CHK("started", rows[i].st, primary_started_flag)
      `CHK("running", rows[i].rn, secondary_running_flag)
      `CHK("sec_osc", rows[i].seco, sec_osc_en)
      `CHK("irc_osc", rows[i].irco, irc_osc_en)
      if (rows[i].src == 2'h2) `CHK("freq_stable", 1'b1, internal_freq_stable_flag)
    end
    primary_source_config = 3'h1;
    sleep_wake(2'h0, c1, p1);
    `CHK("wake00_startup", 1'b1, p1 >= 1024 && c1 >= 250)
    wr(1'b0, 1'b0, 1'b1, 2'h1);
    wait_sig(0, c1, p1, lo);
    wait_sig(1, c1, p1, lo);
    sleep_wake(2'h1, c1, p1);
    `CHK("wake01_fast", 1'b1, c1 >= 250 && p1 < 1024)
    wr(1'b0, 1'b0, 1'b1, 2'h0);
    repeat (2) @(negedge clk_sys);
    sleep_wake(2'h0, c1, p1);
    `CHK("sleep_in_startup", 1'b1, p1 >= 1024)
    `CHK("sleep_in_startup_src", 2'h0, sys_clk_source)
    wr(1'b0, 1'b0, 1'b1, 2'h2);
    wait_sig(0, c1, p1, lo);
    wr(1'b0, 1'b0, 1'b1, 2'h0);
    wait_sig(1, c1, p1, lo);
    `CHK("write_in_hold", 2'h2, clock_select_field)
    primary_source_config = 3'h3;
    restart(c1, p1);
    `CHK("short_delay", 1'b1, c1 >= 248 && c1 <= 258)
    primary_source_config = 3'h1;
    two_speed_en = 1'b1;
    restart(c1, p1);
    `CHK("two_speed_early", 1'b1, c1 < 600)
    `CHK("two_speed_src", 2'h2, sys_clk_source)
    wait_sig(2, c1, p1, lo);
    `CHK("two_speed_done", 1'b1, p1 > 700 && lo == 0)
    give_verdict();
  end
endmodule : tb
